// ===== core/tmv_defines.vh
// register offsets, field positions, reset values and field codes for the event timer
`ifndef TMV_DEFINES_VH
`define TMV_DEFINES_VH
// byte addresses of the 32-bit register words
`define TMV_OFF_CLEAR_CLOCK 12'h000
`define TMV_OFF_FLAGS_OUT 12'h004
`define TMV_OFF_CONST_A 12'h008
`define TMV_OFF_CONST_B 12'h00c
`define TMV_OFF_COUNTER 12'h010
`define TMV_OFF_TRIGGER 12'h014
// reset values
`define TMV_RST_CLEAR_CLOCK 8'h00
`define TMV_RST_FLAGS_OUT 8'h10
`define TMV_RST_CONST 8'hff
`define TMV_RST_COUNTER 8'h00
`define TMV_RST_TRIGGER 8'he2
// clear_clock_ctrl fields
`define TMV_BIT_MATCH_B_IRQ_EN 7
`define TMV_BIT_MATCH_A_IRQ_EN 6
`define TMV_BIT_WRAP_IRQ_EN 5
`define TMV_CLR_HI 4
`define TMV_CLR_LO 3
`define TMV_CKS_HI 2
`define TMV_CKS_LO 0
// flags_output_ctrl fields
`define TMV_BIT_MATCH_B_FLAG 7
`define TMV_BIT_MATCH_A_FLAG 6
`define TMV_BIT_WRAP_FLAG 5
`define TMV_BIT_FIXED_ONE 4
// trigger_ctrl fields and read-as-one mask
`define TMV_TRIG_EDGE_HI 4
`define TMV_TRIG_EDGE_LO 3
`define TMV_BIT_TRIGGER_GATE_EN 2
`define TMV_BIT_CLK_SEL_LOW 0
`define TMV_TRIG_FIXED 8'he2
// codes
`define TMV_CLR_NONE 2'b00
`define TMV_CLR_MATCH_A 2'b01
`define TMV_CLR_MATCH_B 2'b10
`define TMV_CLR_PIN 2'b11
`define TMV_OUT_KEEP 2'b00
`define TMV_OUT_LOW 2'b01
`define TMV_OUT_HIGH 2'b10
`define TMV_OUT_TOGGLE 2'b11
`define TMV_CKS_OFF0 3'b000
`define TMV_CKS_DIV4 3'b001
`define TMV_CKS_DIV16 3'b010
`define TMV_CKS_DIV64 3'b011
`define TMV_CKS_OFF1 3'b100
`define TMV_CKS_EXT_RISE 3'b101
`define TMV_CKS_EXT_FALL 3'b110
`define TMV_CKS_EXT_BOTH 3'b111
`endif

// ===== core/tmv_timer.v
// event timer with clear/clock selection, match flags and waveform output, on APB
//
// Contract
// - clear select: none, match A, match B, pin
// - gated mode halts counter on clear until trigger
// - ungated mode keeps counting after clear
// - prescale pairs 4/8, 16/32, 64/128 by low bit
// - internal clock counts on divided clock falling edge
// - codes 000 and 100 stop counting
// - external pin counts rising, falling or both edges
// - hardware sets match B flag on equality
// - hardware sets match A flag on equality
// - hardware sets wrap flag on ff to 00
// - flag clears by writing 0 after reading 1
// - status bit 4 reads one, ignores writes
// - B output select keep, low, high, toggle
// - A output select keep, low, high, toggle
// - simultaneous match priority toggle, high, low
// - all output selects zero disables output
// - output low after reset until first match
// - status register resets on reset and low power
// - match signalled when counter leaves matching value
// - enabled set flag raises interrupt request
//
// The APB slave port and the address map were chosen for this implementation.
`include "tmv_defines.vh"

module tmv_timer (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pins and power state
  input wire ext_clock_pin,
  input wire ext_clear_pin,
  input wire trig_pin,
  input wire low_power,
  output reg wave_out,
  output reg timer_irq
);

  // ==========================================================
  // registers and state
  reg [7:0] clear_clock_ctrl;
  reg [7:0] flags_output_ctrl;
  reg [7:0] constant_a;
  reg [7:0] constant_b;
  reg [7:0] event_counter;
  reg [7:0] trigger_ctrl;
  reg [6:0] prescaler;
  reg ext_clock_d;
  reg ext_clear_d;
  reg trig_d;
  reg halted;
  reg match_a_seen;
  reg match_b_seen;
  reg wrap_seen;
  reg wave_en;

  // ==========================================================
  // decoding helpers
  function [1:0] out_action;
    input [1:0] sel_a;
    input [1:0] sel_b;
    input hit_a;
    input hit_b;
    reg [1:0] a;
    reg [1:0] b;
    begin
      a = hit_a ? sel_a : `TMV_OUT_KEEP;
      b = hit_b ? sel_b : `TMV_OUT_KEEP;
      // toggle outranks high, high outranks low
      if (a == `TMV_OUT_TOGGLE || b == `TMV_OUT_TOGGLE) begin
        out_action = `TMV_OUT_TOGGLE;
      end else if (a == `TMV_OUT_HIGH || b == `TMV_OUT_HIGH) begin
        out_action = `TMV_OUT_HIGH;
      end else if (a == `TMV_OUT_LOW || b == `TMV_OUT_LOW) begin
        out_action = `TMV_OUT_LOW;
      end else begin
        out_action = `TMV_OUT_KEEP;
      end
    end
  endfunction

  function edge_hit;
    input [1:0] mode;
    input now;
    input was;
    begin
      case (mode)
        2'b01: edge_hit = now & ~was;
        2'b10: edge_hit = ~now & was;
        2'b11: edge_hit = now ^ was;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // field views
  wire [2:0] clk_sel = clear_clock_ctrl[`TMV_CKS_HI:`TMV_CKS_LO];
  wire [1:0] clear_sel = {clear_clock_ctrl[`TMV_CLR_HI], clear_clock_ctrl[`TMV_CLR_LO]};
  wire clk_sel_low = trigger_ctrl[`TMV_BIT_CLK_SEL_LOW];
  wire trigger_gate_en = trigger_ctrl[`TMV_BIT_TRIGGER_GATE_EN];
  wire [1:0] trig_edge = {trigger_ctrl[`TMV_TRIG_EDGE_HI], trigger_ctrl[`TMV_TRIG_EDGE_LO]};
  wire [1:0] out_sel_b = flags_output_ctrl[3:2];
  wire [1:0] out_sel_a = flags_output_ctrl[1:0];

  // ==========================================================
  // count enable: divided clock falling edge is prescaler bit going 1 to 0
  reg [6:0] next_prescaler;
  reg tick_int;
  reg count_en;
  always @* begin
    next_prescaler = prescaler + 7'h01;
    tick_int = 1'b0;
    count_en = 1'b0;
    case (clk_sel)
      `TMV_CKS_DIV4: tick_int = clk_sel_low ? (prescaler[2:0] == 3'h7)
                                            : (prescaler[1:0] == 2'h3);
      `TMV_CKS_DIV16: tick_int = clk_sel_low ? (prescaler[4:0] == 5'h1f)
                                             : (prescaler[3:0] == 4'hf);
      `TMV_CKS_DIV64: tick_int = clk_sel_low ? (prescaler == 7'h7f)
                                             : (prescaler[5:0] == 6'h3f);
      default: tick_int = 1'b0;
    endcase
    case (clk_sel)
      `TMV_CKS_EXT_RISE: count_en = edge_hit(2'b01, ext_clock_pin, ext_clock_d);
      `TMV_CKS_EXT_FALL: count_en = edge_hit(2'b10, ext_clock_pin, ext_clock_d);
      `TMV_CKS_EXT_BOTH: count_en = edge_hit(2'b11, ext_clock_pin, ext_clock_d);
      default: count_en = tick_int;
    endcase
  end

  // compare match fires on the count that leaves the matching value
  wire eq_a = (event_counter == constant_a);
  wire eq_b = (event_counter == constant_b);
  wire run = count_en & ~halted;
  wire hit_a = run & eq_a;
  wire hit_b = run & eq_b;
  wire pin_clear = (clear_sel == `TMV_CLR_PIN) & ext_clear_pin & ~ext_clear_d;
  wire trig_evt = edge_hit(trig_edge, trig_pin, trig_d);
  wire do_clear = ((clear_sel == `TMV_CLR_MATCH_A) & hit_a) |
                  ((clear_sel == `TMV_CLR_MATCH_B) & hit_b) | pin_clear;
  wire wrap = run & (event_counter == 8'hff) & ~do_clear;

  // ==========================================================
  // apb decode; single-cycle access, pready high in the access phase
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_map = (paddr == `TMV_OFF_CLEAR_CLOCK) | (paddr == `TMV_OFF_FLAGS_OUT) |
                 (paddr == `TMV_OFF_CONST_A) | (paddr == `TMV_OFF_CONST_B) |
                 (paddr == `TMV_OFF_COUNTER) | (paddr == `TMV_OFF_TRIGGER);
  wire wr_flags = wr & (paddr == `TMV_OFF_FLAGS_OUT);
  wire rd_flags = rd & (paddr == `TMV_OFF_FLAGS_OUT);
  wire wr_cnt = wr & (paddr == `TMV_OFF_COUNTER);

  reg [7:0] rd_byte;
  always @* begin
    case (paddr)
      `TMV_OFF_CLEAR_CLOCK: rd_byte = clear_clock_ctrl;
      `TMV_OFF_FLAGS_OUT: rd_byte = flags_output_ctrl | 8'h10;
      `TMV_OFF_CONST_A: rd_byte = constant_a;
      `TMV_OFF_CONST_B: rd_byte = constant_b;
      `TMV_OFF_COUNTER: rd_byte = event_counter;
      `TMV_OFF_TRIGGER: rd_byte = trigger_ctrl | `TMV_TRIG_FIXED;
      default: rd_byte = 8'h00;
    endcase
  end

  // bus answer registers; pready is registered from the setup phase (psel without penable), so it is high in the access phase
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_map;
      prdata <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // writes land at the access edge, when pready is high
  wire wr_go = wr & pready & hit_map;
  wire rd_go = rd & pready;

  // ==========================================================
  // control registers; low power returns all to reset values
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_clock_ctrl <= `TMV_RST_CLEAR_CLOCK;
      constant_a <= `TMV_RST_CONST;
      constant_b <= `TMV_RST_CONST;
      trigger_ctrl <= `TMV_RST_TRIGGER;
    end else if (low_power) begin
      clear_clock_ctrl <= `TMV_RST_CLEAR_CLOCK;
      constant_a <= `TMV_RST_CONST;
      constant_b <= `TMV_RST_CONST;
      trigger_ctrl <= `TMV_RST_TRIGGER;
    end else if (wr_go) begin
      if (paddr == `TMV_OFF_CLEAR_CLOCK) clear_clock_ctrl <= pwdata[7:0];
      if (paddr == `TMV_OFF_CONST_A) constant_a <= pwdata[7:0];
      if (paddr == `TMV_OFF_CONST_B) constant_b <= pwdata[7:0];
      if (paddr == `TMV_OFF_TRIGGER) trigger_ctrl <= pwdata[7:0] | `TMV_TRIG_FIXED;
    end
  end

  // ==========================================================
  // counter, prescaler, edge history and trigger gate
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_counter <= `TMV_RST_COUNTER;
      prescaler <= 7'h00;
      ext_clock_d <= 1'b0;
      ext_clear_d <= 1'b0;
      trig_d <= 1'b0;
      halted <= 1'b0;
    end else begin
      prescaler <= next_prescaler;
      ext_clock_d <= ext_clock_pin;
      ext_clear_d <= ext_clear_pin;
      trig_d <= trig_pin;
      if (low_power) begin
        event_counter <= `TMV_RST_COUNTER;
        halted <= 1'b0;
      end else begin
        if (wr_go && paddr == `TMV_OFF_COUNTER) begin
          event_counter <= pwdata[7:0];
        end else if (do_clear) begin
          event_counter <= 8'h00;
        end else if (run) begin
          event_counter <= event_counter + 8'h01;
        end
        // halt on clear in gated mode, release on trigger edge
        if (trigger_gate_en && do_clear) begin
          halted <= 1'b1;
        end else if (!trigger_gate_en || trig_evt) begin
          halted <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // flags: set beats clear; clear needs a prior read of 1
  wire [2:0] set_vec = {hit_b, hit_a, wrap};
  wire [2:0] flag_vec = flags_output_ctrl[7:5];
  wire [2:0] seen_vec = {match_b_seen, match_a_seen, wrap_seen};
  wire [2:0] clr_vec = (wr_go && paddr == `TMV_OFF_FLAGS_OUT) ?
                       (seen_vec & ~pwdata[7:5]) : 3'b000;
  wire [2:0] next_flags = set_vec | (flag_vec & ~clr_vec);
  // a read marks only the flag values it returned; a flag set during the access stays armed
  wire [2:0] next_seen = (rd_go && paddr == `TMV_OFF_FLAGS_OUT) ? (seen_vec | prdata[7:5]) :
                         (seen_vec & ~clr_vec);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_output_ctrl <= `TMV_RST_FLAGS_OUT;
      match_b_seen <= 1'b0;
      match_a_seen <= 1'b0;
      wrap_seen <= 1'b0;
    end else if (low_power) begin
      flags_output_ctrl <= `TMV_RST_FLAGS_OUT;
      match_b_seen <= 1'b0;
      match_a_seen <= 1'b0;
      wrap_seen <= 1'b0;
    end else begin
      flags_output_ctrl[7:5] <= next_flags;
      flags_output_ctrl[`TMV_BIT_FIXED_ONE] <= 1'b1;
      if (wr_go && paddr == `TMV_OFF_FLAGS_OUT) begin
        flags_output_ctrl[3:0] <= pwdata[3:0];
      end
      {match_b_seen, match_a_seen, wrap_seen} <= next_seen;
    end
  end

  // ==========================================================
  // waveform output; output pin held low while disabled
  reg [1:0] act;
  always @* begin
    act = out_action(out_sel_a, out_sel_b, hit_a, hit_b);
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_en <= 1'b0;
      wave_out <= 1'b0;
    end else begin
      case (act)
        `TMV_OUT_LOW: wave_en <= 1'b0;
        `TMV_OUT_HIGH: wave_en <= 1'b1;
        `TMV_OUT_TOGGLE: wave_en <= ~wave_en;
        default: wave_en <= wave_en;
      endcase
      wave_out <= (flags_output_ctrl[3:0] == 4'h0) ? 1'b0 : wave_en;
    end
  end

  // ==========================================================
  // interrupt request: any enabled set flag
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |(flag_vec & clear_clock_ctrl[7:5]);
    end
  end

endmodule

// ===== testbench/tmv_pins.sv
// pin-side model: pulses on the external clock, clear and trigger pins
module tmv_pins (
  // clock
  input wire sys_clk,
  // pins into the timer
  output logic ext_clock_pin,
  output logic ext_clear_pin,
  output logic trig_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // pin levels, low from time zero
  logic [2:0] lvl = 3'h0;
  assign {trig_pin, ext_clear_pin, ext_clock_pin} = lvl;
  // each level held 3 cycles: both-edge counting needs 2.5, then a settle gap
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      lvl <= lvl | m;
      repeat (3) @(posedge sys_clk);
      lvl <= lvl & ~m;
      repeat (2) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// ===== testbench/tmv_timer_properties.sv
// port assertions for the event timer, bound into the design
module tmv_timer_properties (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // power and interrupt
  input wire low_power,
  input wire timer_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ====
  // completed transfers, and a shadow of the interrupt enables
  wire done = psel && penable && pready;
  wire rd_ok = done && !pwrite && !pslverr;
  logic [2:0] irq_en;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) irq_en <= 3'h0;
    else if (low_power) irq_en <= 3'h0;
    else if (done && pwrite && paddr == 12'h000) irq_en <= pwdata[7:5];
  end
  // ====
  // properties
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; psel && penable && pready ##1 !pready; endsequence
  property p_answer; s_setup |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("apb answer late");
  property p_unmapped; done && paddr > 12'h014 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_mapped; done && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped refused");
  property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("data outside answer");
  property p_fixed_one; rd_ok && paddr == 12'h004 |-> prdata[4]; endproperty
  a_fixed_one: assert property (p_fixed_one) else $error("bit 4 low");
  property p_trig_ones; rd_ok && paddr == 12'h014 |-> prdata[7:5] == 3'h7 && prdata[1];
  endproperty
  a_trig_ones: assert property (p_trig_ones) else $error("reserved bits low");
  property p_power;
    rd_ok && paddr == 12'h004 && low_power && $past(low_power, 3) |-> prdata[7:0] == 8'h10;
  endproperty
  a_power: assert property (p_power) else $error("status kept in low power");
  property p_irq; timer_irq |-> $past(irq_en) != 3'h0; endproperty
  a_irq: assert property (p_irq) else $error("irq without enable");
endmodule
bind tmv_timer tmv_timer_properties u_props (.sys_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .low_power, .timer_irq);

// ===== testbench/tb_top.sv
// self-checking bench for the event timer
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // signals
  logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, low_power = 1'b0, serr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] rdata;
  wire [31:0] prdata;
  wire pready, pslverr, wave_out, timer_irq, ext_clock_pin, ext_clear_pin, trig_pin;
  int errors = 0, check_count = 0;
  // ====
  // design and pin model
  tmv_timer DUT (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_clock_pin, .ext_clear_pin, .trig_pin, .low_power,
    .wave_out, .timer_irq);
  tmv_pins u_pins (.sys_clk, .ext_clock_pin, .ext_clear_pin, .trig_pin);
  // 25 ns period
  initial forever #12.5 sys_clk = ~sys_clk;
  // ====
  // shared tasks
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one transfer; pready is awaited (only the watchdog ends a hang), answer taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdata = prdata[7:0];
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h0);
    chk(what, exp, rdata);
  endtask
  // ====
  // scenarios
  task automatic t_reset();
    logic [47:0] rv = 48'h0010ffff00e2;
    for (int i = 0; i < 6; i++) rdc("reset", 12'(4 * i), rv[47 - 8 * i -: 8]);
    chk("wave", 8'h0, {7'h0, wave_out});
    apb(1'b0, 12'h018, 8'h0);
    chk("unmapped", 8'h1, {7'h0, serr});
  endtask
  task automatic t_edges();
    logic [14:0] cks = 15'b000_100_101_110_111;
    logic [39:0] cnt = 40'h0000030306;
    wr(12'h014, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wr(12'h000, {5'h0, cks[14 - 3 * i -: 3]});
      wr(12'h010, 8'h00);
      u_pins.pulse(3'h1, 3);
      rdc("edges", 12'h010, cnt[39 - 8 * i -: 8]);
    end
  endtask
  // free-running prescaler: a window of 4N+1 cycles holds 4 or 5 enables
  task automatic t_prescale();
    for (int i = 0; i < 6; i++) begin
      wr(12'h014, 8'(i % 2));
      wr(12'h000, 8'(i / 2 + 1));
      wr(12'h010, 8'h00);
      repeat (16 << i) @(posedge sys_clk);
      apb(1'b0, 12'h010, 8'h0);
      check_count++;
      if (!(rdata === 8'd4 || rdata === 8'd5)) begin
        errors++;
        $display("MISMATCH prescale expected 4 or 5 seen %h", rdata);
      end
    end
  endtask
  task automatic t_match();
    wr(12'h014, 8'h00);
    wr(12'h008, 8'h03);
    wr(12'h000, 8'h05);
    wr(12'h010, 8'h00);
    wr(12'h004, 8'he0);
    u_pins.pulse(3'h1, 3);
    rdc("flags early", 12'h004, 8'h10);
    u_pins.pulse(3'h1, 1);
    wr(12'h004, 8'h00);
    rdc("flag unread", 12'h004, 8'h50);
    wr(12'h004, 8'he0);
    rdc("flag ones", 12'h004, 8'h50);
    wr(12'h004, 8'h00);
    rdc("flag clear", 12'h004, 8'h10);
    rdc("no clear", 12'h010, 8'h04);
    wr(12'h010, 8'hff);
    u_pins.pulse(3'h1, 1);
    rdc("wrap", 12'h010, 8'h00);
    rdc("wrap flags", 12'h004, 8'hb0);
    wr(12'h004, 8'h00);
    rdc("wrap clear", 12'h004, 8'h10);
  endtask
  task automatic t_clear();
    logic [23:0] cc = 24'h0d151d;
    logic [23:0] ex = 24'h020105;
    wr(12'h008, 8'h02);
    wr(12'h00c, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(12'h000, cc[23 - 8 * i -: 8]);
      wr(12'h010, 8'h00);
      u_pins.pulse(3'h1, 5);
      rdc("clear sel", 12'h010, ex[23 - 8 * i -: 8]);
    end
    u_pins.pulse(3'h2, 1);
    rdc("pin clear", 12'h010, 8'h00);
    wr(12'h014, 8'h0c);
    wr(12'h000, 8'h0d);
    u_pins.pulse(3'h4, 1);
    u_pins.pulse(3'h1, 5);
    rdc("halted", 12'h010, 8'h00);
    u_pins.pulse(3'h4, 1);
    u_pins.pulse(3'h1, 1);
    rdc("resumed", 12'h010, 8'h01);
  endtask
  // A and B both match every second pulse; levels alternate 1, 0
  task automatic t_wave();
    logic [47:0] sel = 48'h3c8421d76b20;
    wr(12'h014, 8'h00);
    wr(12'h008, 8'h01);
    wr(12'h010, 8'h00);
    for (int i = 0; i < 12; i++) begin
      wr(12'h004, {4'he, sel[47 - 4 * i -: 4]});
      u_pins.pulse(3'h1, 2);
      chk("wave", {7'h0, i % 2 == 0}, {7'h0, wave_out});
    end
    rdc("match flags", 12'h004, 8'hd0);
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, 8'h0d | (8'h20 << i));
      repeat (3) @(posedge sys_clk);
      chk("irq", {7'h0, i == 1 || i == 2}, {7'h0, timer_irq});
    end
  endtask
  task automatic t_power();
    wr(12'h008, 8'h55);
    wr(12'h004, 8'h03);
    low_power <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdc("low power", 12'h004, 8'h10);
    low_power <= 1'b0;
    rdc("const", 12'h008, 8'hff);
    chk("wave", 8'h0, {7'h0, wave_out});
  endtask
  // ====
  // reset, scenarios, verdict
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_edges();
    t_prescale();
    t_match();
    t_clear();
    t_wave();
    t_power();
    stop_test();
  end
  // watchdog far beyond the expected run
  initial begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
endmodule
